// File: common/dpm_consts.vh
`ifndef DPM_CONSTS_VH
`define DPM_CONSTS_VH

// ==================================================
// Port geometry
`define DPM_PORT_WIDTH 32
`define DPM_LANE_COUNT 4
`define DPM_LANE_WIDTH 8

// ==================================================
// Port operating modes
`define DPM_MODE_MANUAL 2'h0
`define DPM_MODE_SEQUENCER 2'h1
`define DPM_MODE_READOUT 2'h2

// ==================================================
// Sampling clock selection
`define DPM_CLKSEL_INTERNAL 1'b0
`define DPM_CLKSEL_EXTERNAL 1'b1

// ==================================================
// Decimation reset value
`define DPM_DECIM_RESET 5625000

// ==================================================
// Marker source selection
`define DPM_MARK_SEL_BIT 2'h0
`define DPM_MARK_SEL_HIGH 2'h1
`define DPM_MARK_SEL_LOW 2'h2

// ==================================================
// Timing
`define DPM_CLK_PERIOD_NS 50
`define DPM_MARK_STEP_NS 1

// ==================================================
// Trigger generator states
`define DPM_TRG_IDLE 2'h0
`define DPM_TRG_PULSE 2'h1
`define DPM_TRG_HOLD 2'h2

`endif

// File: verilog/dpm_marker.v
`timescale 1ns/1ns
`include "dpm_consts.vh"

module dpm_marker #(
  parameter DEPTH = 16,
  parameter DELAY_WIDTH = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Source and settings
  input wire markerBit,
  input wire [1:0] markerSel,
  input wire [DELAY_WIDTH-1:0] markerDelayNs,
  // Pin
  output reg markerOut
);

  reg [DEPTH-1:0] delayLine;
  reg srcLevel;
  wire [31:0] stepCycles;
  wire [31:0] tapIndex;

  // ==================================================
  // Source selection
  always @* begin
    case (markerSel)
      `DPM_MARK_SEL_BIT: srcLevel = markerBit; // [RULE9]
      `DPM_MARK_SEL_HIGH: srcLevel = 1'b1; // [RULE9]
      `DPM_MARK_SEL_LOW: srcLevel = 1'b0; // [RULE9]
      default: srcLevel = 1'b0;
    endcase
  end

  // ==================================================
  // Delay in 1 ns steps, realised at clock resolution
  assign stepCycles = (markerDelayNs * `DPM_MARK_STEP_NS) / `DPM_CLK_PERIOD_NS; // [RULE10]
  assign tapIndex = (stepCycles > DEPTH - 1) ? DEPTH - 1 : stepCycles;

  always @(posedge clk) begin
    if (rst) begin
      delayLine <= {DEPTH{1'b0}};
      markerOut <= 1'b0;
    end else begin
      delayLine <= {delayLine[DEPTH-2:0], srcLevel};
      if (tapIndex == 0) begin
        markerOut <= srcLevel;
      end else begin
        markerOut <= delayLine[tapIndex-1]; // [RULE10]
      end
    end
  end

endmodule

// File: verilog/dpm_digital_port.v
`timescale 1ns/1ns
`include "dpm_consts.vh"

// Contract
// [RULE1] The port has 32 bits whose direction is set per byte lane by a drive setting.
// [RULE2] Output data is updated on the falling edge of the port clock.
// [RULE3] The sampling clock is driven out on a dedicated pin; the code drives clk divided by two there whatever clockSelect picks.
// [RULE4] Input is sampled by the internal clock or an external clock pin that the far side supplies.
// [RULE5] Sampling clocks are counted to a decimation value and the input latched each time it is reached.
// [RULE6] After reset the decimation value is 5625000 until software loads another.
// [RULE7] Three modes exist: manual, sequencer-driven and readout-driven output.
// [RULE8] Output values reach the pins only on lanes whose drive is on.
// [RULE9] Each marker selects an internal marker bit or constant high or low.
// [RULE10] Each marker has a delay programmed in 1 ns steps.
// [RULE11] The internal trigger emits a programmed number of repeats spaced by a holdoff.
// [RULE12] The 32 bits form four 8-bit buses switched independently.
// [RULE13] A bus with drive on is an output, with drive off an input.
// [RULE14] Software can read the current input values.
// [RULE15] The decimation counter restarts after each latch and the sample holds until the next.
// [RULE16] Changing clock selection or decimation value restarts the counter.

module dpm_digital_port #(
  parameter DECIM_RESET = `DPM_DECIM_RESET,
  parameter MARKER_COUNT = 4,
  parameter MARKER_DEPTH = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Connector pins
  input wire [31:0] parallelDigitalPortIn,
  output reg [31:0] parallelDigitalPortOut,
  output reg [31:0] parallelDigitalPortOe,
  output reg sampleClockOutPin,
  input wire externalSampleClockIn,
  // Port configuration
  input wire [1:0] portMode,
  input wire [3:0] laneDrive,
  input wire [31:0] manualOutput,
  input wire [31:0] sequencerOutput,
  input wire [31:0] readoutSequencerOutput,
  // Input sampling
  input wire clockSelect,
  input wire decimationLoad,
  input wire [31:0] decimationValue,
  output reg [31:0] currentInput,
  output reg [31:0] decimatedSample,
  output reg sampleStrobe,
  output reg [31:0] activeDecimation,
  // Markers
  input wire [MARKER_COUNT-1:0] markerBits,
  input wire [2*MARKER_COUNT-1:0] markerSel,
  input wire [16*MARKER_COUNT-1:0] markerDelayNs,
  output wire [MARKER_COUNT-1:0] markerOut,
  // Internal trigger
  input wire triggerStart,
  input wire [15:0] triggerRepeats,
  input wire [31:0] triggerHoldoff,
  output reg triggerOut,
  output wire triggerBusy
);

  reg [31:0] pinSync1;
  reg [31:0] pinSync2;
  reg [31:0] pinSync3;
  reg extSync1;
  reg extSync2;
  reg extSync3;
  reg extLevel;
  reg extLevelPrev;
  reg clockSelectPrev;
  reg [31:0] decimCount;
  reg [31:0] next_portOut;
  reg [1:0] trgState;
  reg [15:0] trgLeft;
  reg [31:0] trgWait;
  wire [31:0] pinChanged;
  wire extRise;
  wire sampleTick;
  wire restartCount;
  wire [31:0] decimLast;
  wire [31:0] laneEnable;

  // ==================================================
  // Input pin synchronisers, a change counts once stages 2 and 3 agree
  assign pinChanged = pinSync2 ^ pinSync3;

  always @(posedge clk) begin
    if (rst) begin
      pinSync1 <= 32'h00000000;
      pinSync2 <= 32'h00000000;
      pinSync3 <= 32'h00000000;
      currentInput <= 32'h00000000;
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extSync3 <= 1'b0;
      extLevel <= 1'b0;
      extLevelPrev <= 1'b0;
    end else begin
      pinSync1 <= parallelDigitalPortIn;
      pinSync2 <= pinSync1;
      pinSync3 <= pinSync2;
      currentInput <= (pinSync2 & ~pinChanged) | (currentInput & pinChanged); // [RULE14]
      extSync1 <= externalSampleClockIn; // [RULE4]
      extSync2 <= extSync1;
      extSync3 <= extSync2;
      if (extSync2 == extSync3) begin
        extLevel <= extSync2;
      end
      extLevelPrev <= extLevel;
    end
  end

  assign extRise = extLevel & ~extLevelPrev;

  // ==================================================
  // Decimation of the sampling clock
  assign sampleTick = (clockSelect == `DPM_CLKSEL_EXTERNAL) ? extRise : 1'b1; // [RULE4]
  assign restartCount = (clockSelect != clockSelectPrev) || decimationLoad; // [RULE16]
  assign decimLast = (activeDecimation == 32'h00000000) ? 32'h00000000 :
                     activeDecimation - 32'h00000001;

  always @(posedge clk) begin
    if (rst) begin
      activeDecimation <= DECIM_RESET; // [RULE6]
      clockSelectPrev <= `DPM_CLKSEL_INTERNAL;
      decimCount <= 32'h00000000;
      decimatedSample <= 32'h00000000;
      sampleStrobe <= 1'b0;
    end else begin
      clockSelectPrev <= clockSelect;
      sampleStrobe <= 1'b0;
      if (decimationLoad) begin
        activeDecimation <= decimationValue;
      end
      if (restartCount) begin
        decimCount <= 32'h00000000; // [RULE16]
      end else if (sampleTick) begin
        if (decimCount >= decimLast) begin
          decimCount <= 32'h00000000; // [RULE15]
          decimatedSample <= currentInput; // [RULE5]
          sampleStrobe <= 1'b1;
        end else begin
          decimCount <= decimCount + 32'h00000001; // [RULE5]
        end
      end
    end
  end

  // ==================================================
  // Internal clock divided by two driven to the connector, whatever clockSelect picks
  always @(posedge clk) begin
    if (rst) begin
      sampleClockOutPin <= 1'b0;
    end else begin
      sampleClockOutPin <= ~sampleClockOutPin; // [RULE3]
    end
  end

  // ==================================================
  // Output data source and per-lane drive
  always @* begin
    case (portMode)
      `DPM_MODE_MANUAL: next_portOut = manualOutput; // [RULE7]
      `DPM_MODE_SEQUENCER: next_portOut = sequencerOutput; // [RULE7]
      `DPM_MODE_READOUT: next_portOut = readoutSequencerOutput; // [RULE7]
      default: next_portOut = manualOutput;
    endcase
  end

  genvar lane;
  generate
    for (lane = 0; lane < `DPM_LANE_COUNT; lane = lane + 1) begin : gLane
      assign laneEnable[lane*8 +: 8] = {8{laneDrive[lane]}}; // [RULE12] [RULE13] [RULE1]
    end
  endgenerate

  always @(negedge clk) begin
    if (rst) begin
      parallelDigitalPortOut <= 32'h00000000;
      parallelDigitalPortOe <= 32'h00000000;
    end else begin
      parallelDigitalPortOut <= next_portOut & laneEnable; // [RULE2] [RULE8]
      parallelDigitalPortOe <= laneEnable; // [RULE8] [RULE13]
    end
  end

  // ==================================================
  // Marker outputs
  genvar mk;
  generate
    for (mk = 0; mk < MARKER_COUNT; mk = mk + 1) begin : gMarker
      dpm_marker #(
        .DEPTH(MARKER_DEPTH),
        .DELAY_WIDTH(16)
      ) uMarker (
        .clk(clk),
        .rst(rst),
        .markerBit(markerBits[mk]),
        .markerSel(markerSel[mk*2 +: 2]),
        .markerDelayNs(markerDelayNs[mk*16 +: 16]),
        .markerOut(markerOut[mk])
      );
    end
  endgenerate

  // ==================================================
  // Internal trigger generator
  assign triggerBusy = (trgState != `DPM_TRG_IDLE);

  always @(posedge clk) begin
    if (rst) begin
      trgState <= `DPM_TRG_IDLE;
      trgLeft <= 16'h0000;
      trgWait <= 32'h00000000;
      triggerOut <= 1'b0;
    end else begin
      triggerOut <= 1'b0;
      case (trgState)
        `DPM_TRG_IDLE: begin
          if (triggerStart && triggerRepeats != 16'h0000) begin
            trgLeft <= triggerRepeats;
            trgState <= `DPM_TRG_PULSE;
          end
        end
        `DPM_TRG_PULSE: begin
          triggerOut <= 1'b1; // [RULE11]
          trgLeft <= trgLeft - 16'h0001;
          trgWait <= triggerHoldoff;
          if (trgLeft == 16'h0001) begin
            trgState <= `DPM_TRG_IDLE;
          end else begin
            trgState <= `DPM_TRG_HOLD;
          end
        end
        `DPM_TRG_HOLD: begin
          if (trgWait == 32'h00000000) begin
            trgState <= `DPM_TRG_PULSE; // [RULE11]
          end else begin
            trgWait <= trgWait - 32'h00000001;
          end
        end
        default: trgState <= `DPM_TRG_IDLE;
      endcase
    end
  end

endmodule

// File: tb/dpm_far_side.sv
`timescale 1ns/1ns

module dpm_far_side (
  // Device side
  input wire [31:0] portOut,
  input wire [31:0] portOe,
  // Bench control
  input wire [31:0] farData,
  input wire extRun,
  // Lines
  output wire [31:0] portWire,
  output reg extClk
);
  // ==========
  // Far equipment
  initial extClk = 1'b0;
  // Clock only runs inside a frame
  always #200 extClk = extRun ? ~extClk : 1'b0;
  assign portWire = (portOe & portOut) | (~portOe & farData);
endmodule

// File: tb/dpm_port_props.sv
`timescale 1ns/1ns
`include "dpm_consts.vh"

module dpm_port_props #(
  parameter DECIM_RESET = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Port pins and settings
  input wire [31:0] parallelDigitalPortOut,
  input wire [31:0] parallelDigitalPortOe,
  input wire sampleClockOutPin,
  input wire [1:0] portMode,
  input wire [3:0] laneDrive,
  input wire [31:0] manualOutput,
  input wire [31:0] sequencerOutput,
  input wire [31:0] readoutSequencerOutput,
  // Sampling
  input wire clockSelect,
  input wire decimationLoad,
  input wire [31:0] decimationValue,
  input wire [31:0] decimatedSample,
  input wire sampleStrobe,
  input wire [31:0] activeDecimation
);
  wire [31:0] mask = {{8{laneDrive[3]}}, {8{laneDrive[2]}}, {8{laneDrive[1]}}, {8{laneDrive[0]}}};
  wire [31:0] src = portMode == `DPM_MODE_SEQUENCER ? sequencerOutput :
    portMode == `DPM_MODE_READOUT ? readoutSequencerOutput : manualOutput;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_oeLanes;
    !$past(rst) |-> parallelDigitalPortOe == mask;
  endproperty
  a_oeLanes: assert property (p_oeLanes) else $error("lane enable wrong");
  property p_outMasked;
    (parallelDigitalPortOut & ~parallelDigitalPortOe) == 32'h0;
  endproperty
  a_outMasked: assert property (p_outMasked) else $error("undriven lane has data");
  property p_modeMux;
    !$past(rst) |-> parallelDigitalPortOut == (src & mask);
  endproperty
  a_modeMux: assert property (p_modeMux) else $error("output source wrong");
  property p_sampleHold;
    !sampleStrobe |-> $stable(decimatedSample);
  endproperty
  a_sampleHold: assert property (p_sampleHold) else $error("sample changed");
  property p_decimReset;
    $past(rst) |-> activeDecimation == DECIM_RESET;
  endproperty
  a_decimReset: assert property (p_decimReset) else $error("reset decimation");
  property p_firstStrobe;
    disable iff (rst || clockSelect)
    decimationLoad && decimationValue == 32'h3 |=> !sampleStrobe [*3] ##1 sampleStrobe;
  endproperty
  a_firstStrobe: assert property (p_firstStrobe) else $error("restart timing");
  property p_strobeGap;
    disable iff (rst || decimationLoad || clockSelect)
    sampleStrobe && activeDecimation == 32'h3 |=> !sampleStrobe [*2] ##1 sampleStrobe;
  endproperty
  a_strobeGap: assert property (p_strobeGap) else $error("strobe spacing");
  property p_clkOut;
    !$past(rst) |-> sampleClockOutPin != $past(sampleClockOutPin);
  endproperty
  a_clkOut: assert property (p_clkOut) else $error("clock pin stuck");
  c_strobe: cover property (sampleStrobe);
  c_load: cover property (decimationLoad);
  c_drive: cover property (parallelDigitalPortOe != 32'h0);
endmodule

bind dpm_digital_port dpm_port_props #(.DECIM_RESET(DECIM_RESET)) i_dpm_port_props (
  .clk, .rst, .parallelDigitalPortOut, .parallelDigitalPortOe, .sampleClockOutPin,
  .portMode, .laneDrive, .manualOutput, .sequencerOutput, .readoutSequencerOutput,
  .clockSelect, .decimationLoad, .decimationValue, .decimatedSample, .sampleStrobe,
  .activeDecimation);

// File: tb/test_digital_io_port_with_markers.sv
`timescale 1ns/1ns
`include "dpm_consts.vh"

module test_digital_io_port_with_markers;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [1:0] portMode = 2'h0;
  reg [3:0] laneDrive = 4'h0;
  reg [31:0] manualOutput = 32'h11223344;
  reg [31:0] sequencerOutput = 32'h55667788;
  reg [31:0] readoutSequencerOutput = 32'h99AABBCC;
  reg [31:0] farData = 32'hC3A55A3C;
  reg [31:0] decimationValue = 32'h0;
  reg [31:0] expIn = 32'h0;
  reg extRun = 1'b0;
  reg clockSelect = 1'b0;
  reg decimationLoad = 1'b0;
  reg triggerStart = 1'b0;
  reg [15:0] triggerRepeats = 16'h2;
  reg [31:0] triggerHoldoff = 32'h3;
  reg [3:0] markerBits = 4'h0;
  reg [7:0] markerSel = 8'h0;
  reg [63:0] markerDelayNs = 64'h0;
  reg clkPin = 1'b0;
  wire [3:0] markerOut;
  integer mismatches = 0;
  integer comparisons = 0;
  wire [31:0] portOut, portOe, portWire, currentInput, decimatedSample, activeDecimation;
  wire sampleClockOutPin, sampleStrobe, triggerOut, triggerBusy, extClk;

  dpm_digital_port #(.DECIM_RESET(8)) i_dpm_digital_port (
    .clk, .rst, .parallelDigitalPortIn(portWire), .parallelDigitalPortOut(portOut),
    .parallelDigitalPortOe(portOe), .sampleClockOutPin, .externalSampleClockIn(extClk),
    .portMode, .laneDrive, .manualOutput, .sequencerOutput, .readoutSequencerOutput,
    .clockSelect, .decimationLoad, .decimationValue, .currentInput, .decimatedSample,
    .sampleStrobe, .activeDecimation, .markerBits, .markerSel,
    .markerDelayNs, .markerOut, .triggerStart, .triggerRepeats,
    .triggerHoldoff, .triggerOut, .triggerBusy);

  dpm_far_side i_dpm_far_side (.portOut, .portOe, .farData, .extRun, .portWire, .extClk);

  initial begin
    forever #25 clk = ~clk;
  end

  // ==========
  // Helpers
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #5;
    end
  endtask

  task waitStrobe(output integer n);
    begin
      n = 0;
      while (sampleStrobe !== 1'b1 && n < 200) begin
        tick(1);
        n = n + 1;
      end
    end
  endtask

  task load(input [31:0] d, input sel);
    begin
      @(posedge clk);
      decimationLoad <= 1'b1;
      decimationValue <= d;
      clockSelect <= sel;
      extRun <= sel;
      @(posedge clk);
      decimationLoad <= 1'b0;
      #5;
    end
  endtask

  task print_verdict;
    begin
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  // ==========
  // Scenarios
  task t_ports;
    integer m;
    reg [31:0] mask;
    begin
      for (m = 0; m < 4; m = m + 1) begin
        mask = 32'hFF << (8 * m);
        @(posedge clk);
        portMode <= m[1:0];
        laneDrive <= 4'h1 << m;
        tick(8);
        expIn = m == 1 ? sequencerOutput : m == 2 ? readoutSequencerOutput : manualOutput;
        expIn = (expIn & mask) | (farData & ~mask);
        chk(portOut, expIn & mask);
        chk(portOe, mask);
        chk(currentInput, expIn);
      end
    end
  endtask

  task t_decim;
    integer n;
    begin
      load(32'h3, 1'b0);
      chk(activeDecimation, 32'h3);
      waitStrobe(n);
      chk(n, 3);
      chk(decimatedSample, expIn);
      tick(1);
      waitStrobe(n);
      chk(n, 2);
      load(32'h2, 1'b1);
      waitStrobe(n);
      chk(n > 8 && n < 40, 1);
      load(32'h2, 1'b0);
    end
  endtask

  task t_trig(input [15:0] rep, input [31:0] hold);
    integer n;
    integer first;
    integer last;
    integer i;
    begin
      n = 0;
      first = 0;
      last = 0;
      @(posedge clk);
      triggerStart <= 1'b1;
      triggerRepeats <= rep;
      triggerHoldoff <= hold;
      @(posedge clk);
      triggerStart <= 1'b0;
      for (i = 1; i <= 30; i = i + 1) begin
        tick(1);
        if (triggerOut === 1'b1) begin
          if (n == 0)
            first = i;
          last = i;
          n = n + 1;
        end
      end
      chk(n, rep);
      chk(last - first, (rep - 1) * (hold + 2));
      chk(triggerBusy, 1'b0);
    end
  endtask

  // Marker 0 bit undelayed, 1 bit delayed 149 ns (two clocks), 2 high, 3 low
  task t_marker;
    begin
      @(posedge clk);
      markerSel <= {`DPM_MARK_SEL_LOW, `DPM_MARK_SEL_HIGH, `DPM_MARK_SEL_BIT, `DPM_MARK_SEL_BIT};
      markerDelayNs <= {16'h0000, 16'h0000, 16'h0095, 16'h0000};
      markerBits <= 4'h0;
      tick(2);
      chk(markerOut, 4'h4);
      @(posedge clk);
      markerBits <= 4'hF;
      tick(1);
      chk(markerOut, 4'h5);
      tick(1);
      chk(markerOut, 4'h5);
      tick(1);
      chk(markerOut, 4'h7);
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk(activeDecimation, 32'h8);
    clkPin = sampleClockOutPin;
    tick(1);
    chk(sampleClockOutPin, !clkPin);
    t_ports;
    t_decim;
    t_trig(16'h2, 32'h3);
    t_trig(16'h3, 32'h0);
    t_marker;
    print_verdict;
  end

  initial begin
    #30000;
    mismatches = mismatches + 1;
    print_verdict;
  end
endmodule
